// [logic/dff_pkg.sv]
// package: fault flag bit positions, register selectors, timing counts
package dff_pkg;
    localparam int unsigned FLAG_W             = 16;
    // primary register bit positions
    localparam int unsigned P_DSP_SELF         = 15;
    localparam int unsigned P_NVM_CRC          = 14;
    localparam int unsigned P_DSP_MEM_CRC      = 13;
    localparam int unsigned P_TJ_RANGE         = 12;
    localparam int unsigned P_TSENS_PLAUS      = 11;
    localparam int unsigned P_PLATE_SUP_HIGH   = 10;
    localparam int unsigned P_HW_OVERTEMP      = 9;
    localparam int unsigned P_ADC_STUCK        = 7;
    localparam int unsigned P_DECIM_OVF        = 6;
    localparam int unsigned P_AMP_HIGH         = 5;
    localparam int unsigned P_AMP_LOW          = 4;
    localparam int unsigned P_POS_HIGH         = 3;
    localparam int unsigned P_POS_LOW          = 2;
    localparam int unsigned P_PLATE_CUR        = 1;
    // secondary register bit positions
    localparam int unsigned S_GPADC_A          = 14;
    localparam int unsigned S_GPADC_B          = 12;
    localparam int unsigned S_UNDERVOLT        = 11;
    localparam int unsigned S_OVERVOLT         = 10;
    localparam int unsigned S_AVDD_RANGE       = 9;
    localparam int unsigned S_DVDD_RANGE       = 8;
    localparam int unsigned S_UC_SELFTEST      = 7;
    localparam int unsigned S_UC_ROM_OP        = 6;
    localparam int unsigned S_UC_MEM_OP        = 5;
    localparam int unsigned S_ANALOG           = 1;
    // masks of defined bits; everything else reads zero
    localparam logic [15:0] PRI_DEFINED_MASK   = 16'hFEFE;
    localparam logic [15:0] SEC_DEFINED_MASK   = 16'h5F00;
    localparam logic [7:0]  SEC_RESET_MASK     = 8'hE2;
    localparam logic [15:0] FLAGS_RESET_VALUE  = 16'h0000;
    // register select on the read port
    localparam logic        SEL_PRIMARY        = 1'b0;
    localparam logic        SEL_SECONDARY      = 1'b1;
    // hardware overtemperature threshold, degrees C, signed 10-bit code
    localparam int          OVERTEMP_LIMIT_DEGC = 180;
    localparam logic signed [9:0] OVERTEMP_LIMIT = 10'sd180;
    // periodic self-test interval
    localparam int unsigned CLK_MHZ            = 200;
    localparam int unsigned SELFTEST_PERIOD_US = 10;
    localparam int unsigned SELFTEST_CYCLES    = SELFTEST_PERIOD_US * CLK_MHZ;
    localparam logic [15:0] SELFTEST_CYC_W     = 16'(SELFTEST_CYCLES);
    // reset pulse length for severe faults
    localparam logic [3:0]  RST_PULSE_CYC      = 4'h8;
    localparam int unsigned SUMMARY_ERR_BIT    = 0;
endpackage

// [logic/dff_flag_latch.sv]
// sticky-per-test flag bank: flags hold the latest test result
`timescale 1ns/1ps
`default_nettype none
module dff_flag_latch
    import dff_pkg::*;
#(
    parameter int unsigned N = 16
) (
    input  wire logic         clk_sys_i,   // system clock
    input  wire logic         rst_b_i,     // async reset, active low
    input  wire logic         ce_i,        // clock enable
    input  wire logic         sample_i,    // capture strobe
    input  wire logic [N-1:0] cond_i,      // raw fault conditions
    input  wire logic [N-1:0] mask_i,      // defined bit positions
    output logic      [N-1:0] flags_o      // captured flags
);
    logic [N-1:0] flags_ff;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            // a flag takes its condition at each sample so it reads zero after the first sample without the fault
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    flags_ff[g] <= 1'b0;
                end else if (ce_i && sample_i) begin
                    flags_ff[g] <= cond_i[g] & mask_i[g];
                end
            end
        end
    endgenerate

    assign flags_o = flags_ff;
endmodule
`default_nettype wire

// [logic/dff_overtemp.sv]
// hardware overtemperature comparator, independent of the processor
`timescale 1ns/1ps
`default_nettype none
module dff_overtemp
    import dff_pkg::*;
(
    input  wire logic              clk_sys_i,  // system clock
    input  wire logic              rst_b_i,    // async reset, active low
    input  wire logic              ce_i,       // clock enable
    input  wire logic signed [9:0] tj_degc_i,  // junction temperature, degrees C
    output logic                   hot_o       // above limit, registered
);
    logic hot_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hot_ff <= 1'b0;
        end else if (ce_i) begin
            hot_ff <= (tj_degc_i > OVERTEMP_LIMIT);
        end
    end

    assign hot_o = hot_ff;
endmodule
`default_nettype wire

// [logic/dff_diag_top.sv]
// diagnostic fault flag block: two read-only fault registers and frame status
// What this block does
// - run self-tests at start-up and periodically during normal operation
// - on any readable fault, flag failure in status byte of every returned frame
// - both fault registers readable by host over the serial port
// - primary bit 15: signal processor redundancy or plausibility check failed
// - primary bit 14: parameter memory 16-bit checksum failed
// - primary bit 13: processor ROM and RAM checksum mismatch
// - primary bit 12 junction temperature range, bit 11 temp sensor plausibility
// - primary bit 9: hardware supervision, junction above 180 C
// - primary bit 10 plate supply too high, bit 1 plate current range
// - primary bit 7: any of three converter channels stuck
// - primary bit 6: decimation filter overflow or underflow
// - primary bit 5 amplitude above upper limit, bit 4 below lower
// - primary bits 3 and 2: position result above, below valid range
// - secondary bits 14 and 12: general purpose converter error
// - secondary bit 11 undervoltage, bit 10 overvoltage
// - secondary bit 9 analog supply range, bit 8 digital supply range
// - any low-byte secondary fault resets the device, never readable
// - secondary bits 7 controller test, 6 ROM opcode, 5 memory opcode, 1 analog
`timescale 1ns/1ps
`default_nettype none
module dff_diag_top
    import dff_pkg::*;
(
    input  wire logic              clk_sys_i,          // system clock, 200 MHz
    input  wire logic              rst_b_i,            // async reset, active low
    input  wire logic              ce_i,               // clock enable
    // processor and memory checks
    input  wire logic              dsp_self_fail_i,    // redundancy/plausibility fail
    input  wire logic              nvm_crc_fail_i,     // parameter checksum fail
    input  wire logic              dsp_mem_crc_fail_i, // ROM/RAM checksum fail
    // temperature
    input  wire logic              tj_range_fail_i,    // junction temp out of range
    input  wire logic              tsens_plaus_fail_i, // redundant sensor mismatch
    input  wire logic signed [9:0] tj_degc_i,          // junction temperature, C
    // hall plate and signal path
    input  wire logic              plate_sup_high_i,   // plate supply too high
    input  wire logic              plate_cur_fail_i,   // plate current out of range
    input  wire logic [2:0]        adc_stuck_i,        // per-channel stuck result
    input  wire logic              decim_ovf_i,        // decimation overflow
    input  wire logic              decim_unf_i,        // decimation underflow
    input  wire logic              field_amplitude_upper_limit_i, // above upper
    input  wire logic              field_amplitude_lower_limit_i, // below lower
    input  wire logic              pos_high_i,         // position above range
    input  wire logic              pos_low_i,          // position below range
    // supplies and converter
    input  wire logic              gpadc_err_i,        // general converter error
    input  wire logic              undervolt_i,        // supply undervoltage
    input  wire logic              overvolt_i,         // supply overvoltage
    input  wire logic              avdd_fail_i,        // analog supply out of range
    input  wire logic              dvdd_fail_i,        // digital supply out of range
    // severe faults
    input  wire logic              uc_selftest_fail_i, // controller self-test fail
    input  wire logic              uc_rom_op_fail_i,   // ROM opcode error
    input  wire logic              uc_mem_op_fail_i,   // memory opcode error
    input  wire logic              analog_fail_i,      // analog part error
    // register read port from the serial frame logic
    input  wire logic              rd_req_i,           // read strobe, one cycle
    input  wire logic              rd_sel_i,           // 0 primary, 1 secondary
    output logic [15:0]            rd_data_o,          // read data
    output logic                   rd_valid_o,         // read data valid pulse
    // frame status and device control
    output logic                   frame_fail_o,       // failure bit for status byte
    output logic [15:0]            fault_flags_primary_o,   // primary register
    output logic [15:0]            fault_flags_secondary_o, // secondary register
    output logic                   startup_done_o,     // start-up tests complete
    output logic                   dev_reset_o         // device reset request
);
    // ************************************************************
    // self-test sequencing
    // ************************************************************
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN     = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_RESET   = 2'b11
    } dff_state_e;

    dff_state_e  state_ff;
    dff_state_e  nxt_state;
    logic [15:0] period_cnt_ff;
    logic [3:0]  rst_cnt_ff;
    logic        startup_done_ff;
    logic        severe;
    logic        sample;

    // state decodes shared by the period counter, the flags and the reset request
    function automatic logic is_sample(input dff_state_e st);
        return (st == ST_SAMPLE);
    endfunction

    function automatic logic is_reset(input dff_state_e st);
        return (st == ST_RESET);
    endfunction

    // severe faults bypass the sampling schedule so the reset is immediate
    assign severe = uc_selftest_fail_i | uc_rom_op_fail_i | uc_mem_op_fail_i
                  | analog_fail_i;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STARTUP: nxt_state = ST_SAMPLE;
            ST_RUN: begin
                if (period_cnt_ff == 16'h0000) begin
                    nxt_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: nxt_state = ST_RUN;
            ST_RESET: begin
                if (rst_cnt_ff == 4'h0 && !severe) begin
                    nxt_state = ST_STARTUP;
                end
            end
            default: nxt_state = ST_STARTUP;
        endcase
        if (severe) begin
            nxt_state = ST_RESET;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_STARTUP;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            period_cnt_ff <= 16'h0000;
        end else if (ce_i) begin
            if (is_sample(state_ff)) begin
                // two short: the sample cycle and the cycle at count zero complete the period
                period_cnt_ff <= SELFTEST_CYC_W - 16'h0002;
            end else if (period_cnt_ff != 16'h0000) begin
                period_cnt_ff <= period_cnt_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_cnt_ff <= 4'h0;
        end else if (ce_i) begin
            if (severe) begin
                rst_cnt_ff <= RST_PULSE_CYC;
            end else if (rst_cnt_ff != 4'h0) begin
                rst_cnt_ff <= rst_cnt_ff - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            startup_done_ff <= 1'b0;
        end else if (ce_i) begin
            if (is_reset(nxt_state)) begin
                startup_done_ff <= 1'b0;
            end else if (is_sample(state_ff)) begin
                startup_done_ff <= 1'b1;
            end
        end
    end

    assign sample = is_sample(state_ff);

    // ************************************************************
    // fault condition vectors
    // ************************************************************
    logic        hot;
    logic [15:0] pri_cond;
    logic [15:0] sec_cond;
    logic [15:0] pri_flags;
    logic [15:0] sec_flags;

    dff_overtemp u_overtemp (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .tj_degc_i (tj_degc_i),
        .hot_o     (hot)
    );

    always_comb begin
        pri_cond = FLAGS_RESET_VALUE;
        pri_cond[P_DSP_SELF]       = dsp_self_fail_i;
        pri_cond[P_NVM_CRC]        = nvm_crc_fail_i;
        pri_cond[P_DSP_MEM_CRC]    = dsp_mem_crc_fail_i;
        pri_cond[P_TJ_RANGE]       = tj_range_fail_i;
        pri_cond[P_TSENS_PLAUS]    = tsens_plaus_fail_i;
        pri_cond[P_PLATE_SUP_HIGH] = plate_sup_high_i;
        pri_cond[P_HW_OVERTEMP]    = hot;
        pri_cond[P_ADC_STUCK]      = |adc_stuck_i;
        pri_cond[P_DECIM_OVF]      = decim_ovf_i | decim_unf_i;
        pri_cond[P_AMP_HIGH]       = field_amplitude_upper_limit_i;
        pri_cond[P_AMP_LOW]        = field_amplitude_lower_limit_i;
        pri_cond[P_POS_HIGH]       = pos_high_i;
        pri_cond[P_POS_LOW]        = pos_low_i;
        pri_cond[P_PLATE_CUR]      = plate_cur_fail_i;
    end

    // low byte stays zero: those faults reset the device before any read
    always_comb begin
        sec_cond = FLAGS_RESET_VALUE;
        sec_cond[S_GPADC_A]    = gpadc_err_i;
        sec_cond[S_GPADC_B]    = gpadc_err_i;
        sec_cond[S_UNDERVOLT]  = undervolt_i;
        sec_cond[S_OVERVOLT]   = overvolt_i;
        sec_cond[S_AVDD_RANGE] = avdd_fail_i;
        sec_cond[S_DVDD_RANGE] = dvdd_fail_i;
    end

    dff_flag_latch #(
        .N (FLAG_W)
    ) u_pri_latch (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .sample_i  (sample),
        .cond_i    (pri_cond),
        .mask_i    (PRI_DEFINED_MASK),
        .flags_o   (pri_flags)
    );

    dff_flag_latch #(
        .N (FLAG_W)
    ) u_sec_latch (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .sample_i  (sample),
        .cond_i    (sec_cond),
        .mask_i    (SEC_DEFINED_MASK),
        .flags_o   (sec_flags)
    );

    // ************************************************************
    // outputs and read port
    // ************************************************************
    logic [15:0] rd_data_ff;
    logic        rd_valid_ff;
    logic        frame_fail_ff;
    logic [15:0] pri_out_ff;
    logic [15:0] sec_out_ff;
    logic        dev_reset_ff;

    // register copies trail the latch by one cycle so each output is a flip-flop
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pri_out_ff <= FLAGS_RESET_VALUE;
            sec_out_ff <= FLAGS_RESET_VALUE;
        end else if (ce_i) begin
            pri_out_ff <= pri_flags;
            sec_out_ff <= sec_flags;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_ff  <= FLAGS_RESET_VALUE;
            rd_valid_ff <= 1'b0;
        end else if (ce_i) begin
            // answer exactly one cycle after the strobe, back to back allowed
            rd_valid_ff <= rd_req_i;
            if (rd_req_i) begin
                rd_data_ff <= (rd_sel_i == SEL_SECONDARY) ? sec_flags : pri_flags;
            end
        end
    end

    // status failure bit is any readable flag set, refreshed every cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_fail_ff <= 1'b0;
        end else if (ce_i) begin
            frame_fail_ff <= (|pri_flags) | (|sec_flags);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev_reset_ff <= 1'b0;
        end else if (ce_i) begin
            // taken from next state so the request rises the cycle after the fault
            dev_reset_ff <= is_reset(nxt_state);
        end
    end

    assign rd_data_o               = rd_data_ff;
    assign rd_valid_o              = rd_valid_ff;
    assign frame_fail_o            = frame_fail_ff;
    assign fault_flags_primary_o   = pri_out_ff;
    assign fault_flags_secondary_o = sec_out_ff;
    assign startup_done_o          = startup_done_ff;
    assign dev_reset_o             = dev_reset_ff;
endmodule
`default_nettype wire

// [tb/dff_diag_monitor.sv]
// checker: concurrent assertions on the fault flag block's ports
`timescale 1ns/1ps
`default_nettype none
module dff_diag_monitor
    import dff_pkg::*;
(
    input  wire logic        clk_sys_i,               // system clock
    input  wire logic        rst_b_i,                 // async reset, active low
    input  wire logic        ce_i,                    // clock enable
    input  wire logic        rd_req_i,                // read strobe
    input  wire logic        rd_sel_i,                // register select
    input  wire logic [15:0] rd_data_o,               // read data
    input  wire logic        rd_valid_o,              // read data valid
    input  wire logic        frame_fail_o,            // frame status failure
    input  wire logic [15:0] fault_flags_primary_o,   // primary register
    input  wire logic [15:0] fault_flags_secondary_o, // secondary register
    input  wire logic        startup_done_o,          // start-up tests complete
    input  wire logic        dev_reset_o,             // device reset request
    input  wire logic        uc_selftest_fail_i,      // severe fault
    input  wire logic        uc_rom_op_fail_i,        // severe fault
    input  wire logic        uc_mem_op_fail_i,        // severe fault
    input  wire logic        analog_fail_i            // severe fault
);
    // ***********************************************
    // properties
    // ***********************************************
    logic severe;
    assign severe = uc_selftest_fail_i | uc_rom_op_fail_i | uc_mem_op_fail_i | analog_fail_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    read_answer_a: assert property (rd_req_i && ce_i |=> rd_valid_o)
        else $error("read request not answered next cycle");
    valid_pulse_a: assert property (!rd_req_i && ce_i |=> !rd_valid_o)
        else $error("read valid without a request");
    rd_reserved_a: assert property (rd_valid_o |-> (rd_data_o &
        ~($past(rd_sel_i) ? SEC_DEFINED_MASK : PRI_DEFINED_MASK)) == 16'h0000)
        else $error("reserved or reset-class bit read as one");
    pri_reserved_a: assert property (
        (fault_flags_primary_o & ~PRI_DEFINED_MASK) == 16'h0000)
        else $error("primary reserved bit set");
    sec_reserved_a: assert property (
        (fault_flags_secondary_o & ~SEC_DEFINED_MASK) == 16'h0000)
        else $error("secondary reserved or low bit set");
    frame_fail_a: assert property (frame_fail_o ==
        ((|fault_flags_primary_o) || (|fault_flags_secondary_o)))
        else $error("frame failure bit disagrees with flags");
    gpadc_pair_a: assert property (
        fault_flags_secondary_o[14] == fault_flags_secondary_o[12])
        else $error("converter error bits differ");
    severe_reset_a: assert property (severe && ce_i |=> dev_reset_o)
        else $error("severe fault without reset request");
    reset_hold_a: assert property (severe ##1 !severe |->
        dev_reset_o [*7] ##[1:12] !dev_reset_o)
        else $error("reset request length wrong");
    startup_run_a: assert property ($rose(rst_b_i) |-> ##[1:8] startup_done_o)
        else $error("start-up test not done in time");

    cover property (severe ##1 dev_reset_o);
    cover property (rd_valid_o && rd_data_o != 16'h0000);
    cover property ($rose(frame_fail_o));
    cover property (fault_flags_secondary_o[14]);
endmodule

bind dff_diag_top dff_diag_monitor u_mon (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .rd_req_i(rd_req_i),
    .rd_sel_i(rd_sel_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .frame_fail_o(frame_fail_o), .fault_flags_primary_o(fault_flags_primary_o),
    .fault_flags_secondary_o(fault_flags_secondary_o), .startup_done_o(startup_done_o),
    .dev_reset_o(dev_reset_o), .uc_selftest_fail_i(uc_selftest_fail_i),
    .uc_rom_op_fail_i(uc_rom_op_fail_i), .uc_mem_op_fail_i(uc_mem_op_fail_i),
    .analog_fail_i(analog_fail_i));
`default_nettype wire

// [tb/dff_spi_host.sv]
// partner model: serial host frame logic polling the fault registers
`timescale 1ns/1ps
`default_nettype none
module dff_spi_host (
    input  wire logic        clk_sys_i,  // system clock
    input  wire logic [15:0] rd_data_i,  // read data from the block
    input  wire logic        rd_valid_i, // read data valid
    output logic             rd_req_o,   // read strobe
    output logic             rd_sel_o    // register select
);
    initial begin
        rd_req_o = 1'b0;
        rd_sel_o = 1'b0;
    end
    // gap lets the host poll slowly; select is inverted afterwards so a stale one is not reused
    task automatic read_reg(input logic sel, output logic [15:0] data, input int gap);
        data = 'x;
        repeat (gap) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        rd_req_o <= 1'b1;
        rd_sel_o <= sel;
        @(posedge clk_sys_i);
        rd_req_o <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk_sys_i);
            if (rd_valid_i === 1'b1) begin
                data = rd_data_i;
                break;
            end
        end
        rd_sel_o <= ~sel;
    endtask
endmodule
`default_nettype wire

// [tb/diagnostic_fault_flags_tb_top.sv]
// testbench: fault register reads, start-up and periodic tests, severe faults
`timescale 1ns/1ps
`default_nettype none
module diagnostic_fault_flags_tb_top import dff_pkg::*;;
    // ***********************************************
    // stimulus and checking
    // ***********************************************
    localparam int PPOS [16] = '{15, 14, 13, 12, 11, 10, 7, 7, 7, 6, 6, 5, 4, 3, 2, 1};
    localparam logic [15:0] SEXP [5] = '{16'h5000, 16'h0800, 16'h0400, 16'h0200, 16'h0100};
    logic              clk_sys = 1'b0;
    logic              rst_b;
    logic              ce;
    logic [24:0]       flt;
    logic signed [9:0] tj;
    logic              rd_req, rd_sel, rd_valid, frame_fail, startup_done, dev_reset;
    logic [15:0]       rd_data, pri, sec;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    always #2.5 clk_sys = ~clk_sys;

    dff_diag_top dut (
        .clk_sys_i(clk_sys), .rst_b_i(rst_b), .ce_i(ce),
        .dsp_self_fail_i(flt[0]), .nvm_crc_fail_i(flt[1]), .dsp_mem_crc_fail_i(flt[2]),
        .tj_range_fail_i(flt[3]), .tsens_plaus_fail_i(flt[4]), .tj_degc_i(tj),
        .plate_sup_high_i(flt[5]), .plate_cur_fail_i(flt[15]), .adc_stuck_i(flt[8:6]),
        .decim_ovf_i(flt[9]), .decim_unf_i(flt[10]),
        .field_amplitude_upper_limit_i(flt[11]), .field_amplitude_lower_limit_i(flt[12]),
        .pos_high_i(flt[13]), .pos_low_i(flt[14]), .gpadc_err_i(flt[16]),
        .undervolt_i(flt[17]), .overvolt_i(flt[18]), .avdd_fail_i(flt[19]),
        .dvdd_fail_i(flt[20]), .uc_selftest_fail_i(flt[21]), .uc_rom_op_fail_i(flt[22]),
        .uc_mem_op_fail_i(flt[23]), .analog_fail_i(flt[24]), .rd_req_i(rd_req),
        .rd_sel_i(rd_sel), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .frame_fail_o(frame_fail), .fault_flags_primary_o(pri),
        .fault_flags_secondary_o(sec), .startup_done_o(startup_done), .dev_reset_o(dev_reset));

    dff_spi_host host (.clk_sys_i(clk_sys), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .rd_req_o(rd_req), .rd_sel_o(rd_sel));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_done();
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (startup_done === 1'b1) break;
        end
        repeat (2) @(posedge clk_sys);
    endtask

    // full reset makes the block resample at once instead of waiting a whole period
    task automatic restart();
        rst_b <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_done();
    endtask

    task automatic read_pair(input logic [15:0] ep, input logic [15:0] es, input int gap);
        logic [15:0] d;
        host.read_reg(SEL_PRIMARY, d, gap);
        chk("primary read", d, ep);
        host.read_reg(SEL_SECONDARY, d, 0);
        chk("secondary read", d, es);
        chk("primary copy", pri, ep);
        chk("secondary copy", sec, es);
        chk("frame failure", {15'h0000, frame_fail}, {15'h0000, (ep | es) != 16'h0000});
    endtask

    task automatic t_each();
        for (int i = 0; i < 21; i++) begin
            flt <= 25'h000_0001 << i;
            restart();
            read_pair(i < 16 ? 16'h0001 << PPOS[i] : 16'h0000,
                i < 16 ? 16'h0000 : SEXP[i - 16], i % 3);
        end
        flt <= 25'h1f_ffff;
        tj <= 10'sd181;
        restart();
        read_pair(16'hfefe, 16'h5f00, 0);
        $display("test single and all faults done");
    endtask

    task automatic t_overtemp();
        flt <= 25'h000_0000;
        tj <= 10'sd180;
        restart();
        read_pair(16'h0000, 16'h0000, 1);
        tj <= 10'sd181;
        restart();
        read_pair(16'h0200, 16'h0000, 0);
        $display("test overtemperature done");
    endtask

    task automatic t_periodic();
        tj <= 10'sd25;
        restart();
        flt[1] <= 1'b1;
        read_pair(16'h0000, 16'h0000, 0);
        repeat (2000) @(posedge clk_sys);
        read_pair(16'h4000, 16'h0000, 0);
        flt[1] <= 1'b0;
        repeat (2000) @(posedge clk_sys);
        read_pair(16'h0000, 16'h0000, 0);
        $display("test periodic done");
    endtask

    task automatic t_severe();
        logic seen;
        for (int k = 0; k < 4; k++) begin
            seen = 1'b0;
            flt <= 25'h020_0000 << k;
            @(posedge clk_sys);
            flt <= 25'h000_0000;
            for (int n = 0; n < 5; n++) begin
                @(posedge clk_sys);
                seen = seen | (dev_reset === 1'b1);
            end
            chk("device reset request", {15'h0000, seen}, 16'h0001);
            for (int n = 0; n < 30 && dev_reset !== 1'b0; n++) @(posedge clk_sys);
            wait_done();
            chk("start-up after reset", {15'h0000, startup_done}, 16'h0001);
            read_pair(16'h0000, 16'h0000, 0);
        end
        $display("test severe faults done");
    endtask

    // enable low right after reset must hold the sequencer in start-up
    task automatic t_freeze();
        rst_b <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("frozen start-up", {15'h0000, startup_done}, 16'h0000);
        ce <= 1'b1;
        wait_done();
        chk("start-up after enable", {15'h0000, startup_done}, 16'h0001);
        $display("test clock enable done");
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        flt = 25'h000_0000;
        tj = 10'sd25;
        restart();
        read_pair(16'h0000, 16'h0000, 0);
        $display("test clean start done");
        t_each();
        t_overtemp();
        t_periodic();
        t_severe();
        t_freeze();
        wrap_up();
    end
endmodule
`default_nettype wire
